// ==== rtl/scs_core_clock_select.sv ====
/*
 * Core clock source selector: internal oscillator with power-of-two
 * divider, external oscillator, real-time clock oscillator, or a clock
 * multiplier with fractional scaling. Produces core_clock as a
 * registered square wave.
 * Assumes each oscillator arrives as a one-cycle tick per oscillator
 * edge, synchronous to clk, at well under half the clk rate.
 */
`timescale 1ns/100ps

module scs_core_clock_select
    import scs_pkg::*;
#(
    parameter logic [SCS_CAL_W-1:0] CAL_RESET = 7'h40,
    parameter logic [SCS_STALL_W-1:0] STALL_CYCLES = 16'h1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] source_select,
    input wire logic internal_osc_control_enable,
    input wire logic [SCS_CAL_W-1:0] internal_osc_calibration,
    input wire logic [2:0] internal_osc_divide_select,
    input wire logic [1:0] mult_base_select,
    input wire logic [2:0] mult_scale_select,
    input wire logic int_osc_tick,
    input wire logic ext_osc_tick,
    input wire logic rtc_osc_tick,
    output logic core_clock,
    output logic [1:0] core_clock_source,
    output logic internal_osc_run,
    output logic [SCS_CAL_W-1:0] internal_osc_trim,
    output logic internal_osc_ready,
    output logic switch_pending
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    scs_state_t state, next_state;
    scs_src_t src, next_src;
    scs_base_t base, next_base;
    logic [2:0] scale, next_scale;
    logic [2:0] div, next_div;
    logic next_core_clock;
    logic next_internal_osc_run;
    logic [SCS_CAL_W-1:0] next_internal_osc_trim;
    logic next_internal_osc_ready;
    logic [SCS_DIV_CNT_W-1:0] div_cnt, next_div_cnt;
    logic [SCS_PER_W-1:0] per_cnt, next_per_cnt;
    logic [SCS_PER_W-1:0] period, next_period;
    logic [SCS_PER_W+3:0] acc, next_acc;
    logic [SCS_STALL_W-1:0] stall, next_stall;
    logic per_armed, next_per_armed;
    logic next_switch_pending;

    // ---------------------------------------------------------------
    // combinational helpers
    // ---------------------------------------------------------------
    logic int_tick;
    logic div_tick;
    logic mult_src_tick;
    logic mult_tick;
    logic sel_tick;
    logic pend;
    logic [SCS_DIV_CNT_W-1:0] div_last;
    logic [3:0] step;
    logic [2:0] den;
    logic [SCS_PER_W+3:0] thr;
    logic [SCS_PER_W+3:0] acc_sum;

    always_comb begin
        int_tick = int_osc_tick & internal_osc_run;
        div_last = SCS_DIV_CNT_W'((8'h01 << div) - 8'h01);
        div_tick = int_tick && (div_cnt == div_last);
        // the multiplier runs from a measured source period so its
        // output ticks come evenly spaced, not in bursts
        mult_src_tick = (base == SCS_BASE_INT_X2) ? int_tick
                                                   : ext_osc_tick;
        step = (base == SCS_BASE_EXT_X4) ? SCS_STEP_X4 : SCS_STEP_X2;
        den = (scale > SCS_SCALE_MAX) ? SCS_SCALE_DEN_MAX
                                      : scale + SCS_SCALE_OFFSET;
        thr = (SCS_PER_W+4)'(period) * (SCS_PER_W+4)'(den);
        acc_sum = acc + (SCS_PER_W+4)'(step);
        mult_tick = (base != SCS_BASE_NONE) && (period != '0)
                    && (acc_sum >= thr);
        case (src)
            SCS_SRC_INT: sel_tick = div_tick;
            SCS_SRC_EXT: sel_tick = ext_osc_tick;
            SCS_SRC_RTC: sel_tick = rtc_osc_tick;
            SCS_SRC_MULT: sel_tick = mult_tick;
            default: sel_tick = 1'b0;
        endcase
        pend = (source_select != src) || (mult_base_select != base)
               || (mult_scale_select != scale)
               || (internal_osc_divide_select != div);
    end

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_src = src;
        next_base = base;
        next_scale = scale;
        next_div = div;
        next_core_clock = core_clock;
        next_internal_osc_run = internal_osc_control_enable;
        next_internal_osc_trim = internal_osc_calibration;
        next_internal_osc_ready = internal_osc_ready;
        next_div_cnt = div_cnt;
        next_per_cnt = per_cnt;
        next_period = period;
        next_acc = acc;
        next_stall = stall;
        next_per_armed = per_armed;

        if (!internal_osc_run) begin
            next_internal_osc_ready = 1'b0;
        end else if (int_osc_tick) begin
            next_internal_osc_ready = 1'b1;
        end

        if (int_tick) begin
            next_div_cnt = div_tick ? '0 : div_cnt + 1'b1;
        end

        // first source tick after a switch lands at a random phase, so it
        // only starts the count; a partial period would give runt pulses
        if (mult_src_tick) begin
            next_per_armed = 1'b1;
            if (per_armed) begin
                next_period = per_cnt + 1'b1;
            end
            next_per_cnt = '0;
        end else if (per_cnt != '1) begin
            next_per_cnt = per_cnt + 1'b1;
        end
        next_acc = mult_tick ? acc_sum - thr : acc_sum;
        if (period == '0) begin
            next_acc = '0;
        end

        if (sel_tick) begin
            next_core_clock = ~core_clock;
            next_stall = '0;
        end else if (stall != '1) begin
            next_stall = stall + 1'b1;
        end

        case (state)
            SCS_ST_RUN: begin
                if (pend) begin
                    next_state = SCS_ST_SWITCH;
                end
            end
            SCS_ST_SWITCH: begin
                // change only on a falling edge so the old source ends with
                // a full high phase; a dead source is left after a
                // stall, since a stopped clock cannot be cut short
                if ((sel_tick && core_clock) || stall >= STALL_CYCLES) begin
                    next_state = SCS_ST_RUN;
                    next_src = scs_src_t'(source_select);
                    next_base = scs_base_t'(mult_base_select);
                    next_scale = mult_scale_select;
                    next_div = internal_osc_divide_select;
                    next_core_clock = 1'b0;
                    next_div_cnt = '0;
                    next_per_cnt = '0;
                    next_period = '0;
                    next_acc = '0;
                    next_stall = '0;
                    next_per_armed = 1'b0;
                end
            end
            default: next_state = SCS_ST_RUN;
        endcase
        next_switch_pending = (next_state == SCS_ST_SWITCH);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SCS_ST_RUN;
            src <= SCS_SRC_INT;
            base <= SCS_BASE_INT_X2;
            scale <= SCS_SCALE_RESET;
            div <= SCS_DIV_RESET;
            core_clock <= 1'b0;
            internal_osc_run <= 1'b1;
            internal_osc_trim <= CAL_RESET;
            internal_osc_ready <= 1'b0;
            div_cnt <= '0;
            per_cnt <= '0;
            period <= '0;
            acc <= '0;
            stall <= '0;
            per_armed <= 1'b0;
            core_clock_source <= SCS_SRC_INT;
            switch_pending <= 1'b0;
        end else begin
            state <= next_state;
            src <= next_src;
            base <= next_base;
            scale <= next_scale;
            div <= next_div;
            core_clock <= next_core_clock;
            internal_osc_run <= next_internal_osc_run;
            internal_osc_trim <= next_internal_osc_trim;
            internal_osc_ready <= next_internal_osc_ready;
            div_cnt <= next_div_cnt;
            per_cnt <= next_per_cnt;
            period <= next_period;
            acc <= next_acc;
            stall <= next_stall;
            core_clock_source <= next_src;
            per_armed <= next_per_armed;
            switch_pending <= next_switch_pending;
        end
    end

endmodule

// ==== rtl/scs_pkg.sv ====
/*
 * Constants and types for the core clock source selector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scs_pkg;

    // ---------------------------------------------------------------
    // source, multiplier and state encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SCS_SRC_INT  = 2'b00,
        SCS_SRC_EXT  = 2'b01,
        SCS_SRC_RTC  = 2'b10,
        SCS_SRC_MULT = 2'b11
    } scs_src_t;

    typedef enum logic [1:0] {
        SCS_BASE_INT_X2 = 2'b00,
        SCS_BASE_EXT_X2 = 2'b01,
        SCS_BASE_EXT_X4 = 2'b10,
        SCS_BASE_NONE   = 2'b11
    } scs_base_t;

    typedef enum logic {
        SCS_ST_RUN    = 1'b0,
        SCS_ST_SWITCH = 1'b1
    } scs_state_t;

    // ---------------------------------------------------------------
    // reset values and field limits
    // ---------------------------------------------------------------
    localparam logic [2:0] SCS_DIV_RESET = 3'h7;
    localparam logic [2:0] SCS_SCALE_RESET = 3'h0;
    localparam logic [2:0] SCS_SCALE_MAX = 3'h5;
    localparam logic [2:0] SCS_SCALE_OFFSET = 3'h2;
    localparam logic [2:0] SCS_SCALE_DEN_MAX = 3'h7;
    localparam logic [3:0] SCS_STEP_X2 = 4'h4;
    localparam logic [3:0] SCS_STEP_X4 = 4'h8;
    localparam int SCS_CAL_W = 7;
    localparam int SCS_DIV_CNT_W = 7;
    localparam int SCS_PER_W = 16;
    localparam int SCS_STALL_W = 16;

endpackage

// ==== bench/scs_core_clock_select_assertions.sv ====
/* Port checker for the core clock selector.
   Assumes a bind onto scs_core_clock_select, one clock. */
`timescale 1ns/100ps

module scs_core_clock_select_assertions
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic internal_osc_control_enable,
    input wire logic [SCS_CAL_W-1:0] internal_osc_calibration,
    input wire logic int_osc_tick,
    input wire logic ext_osc_tick,
    input wire logic rtc_osc_tick,
    input wire logic core_clock,
    input wire logic [1:0] core_clock_source,
    input wire logic internal_osc_run,
    input wire logic [SCS_CAL_W-1:0] internal_osc_trim,
    input wire logic internal_osc_ready,
    input wire logic switch_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_switch_done;
        ##[1:1000] $fell(switch_pending);
    endsequence

    reset_state_a: assert property (
        $fell(rst) |-> !core_clock && core_clock_source == SCS_SRC_INT)
        else $error("state after reset wrong");
    osc_follow_a: assert property (
        1 |=> internal_osc_run == $past(internal_osc_control_enable) &&
        internal_osc_trim == $past(internal_osc_calibration))
        else $error("oscillator enable or trim not passed on");
    ready_off_a: assert property (
        !internal_osc_control_enable [*3] |-> !internal_osc_ready)
        else $error("ready while oscillator disabled");
    src_pending_a: assert property (
        $changed(core_clock_source) |-> $past(switch_pending))
        else $error("source changed without pending switch");
    src_low_a: assert property (
        $changed(core_clock_source) |-> !core_clock)
        else $error("source changed with core clock high");
    toggle_tick_a: assert property (
        $changed(core_clock) && core_clock_source != SCS_SRC_MULT |->
        $past(int_osc_tick) || $past(ext_osc_tick) || $past(rtc_osc_tick) ||
        $past(switch_pending))
        else $error("core clock moved without a tick");
    switch_bound_a: assert property (
        $rose(switch_pending) |-> s_switch_done)
        else $error("switch never completed");
endmodule

bind scs_core_clock_select scs_core_clock_select_assertions i_chk (
    .clk(clk),
    .rst(rst),
    .internal_osc_control_enable(internal_osc_control_enable),
    .internal_osc_calibration(internal_osc_calibration),
    .int_osc_tick(int_osc_tick),
    .ext_osc_tick(ext_osc_tick),
    .rtc_osc_tick(rtc_osc_tick),
    .core_clock(core_clock),
    .core_clock_source(core_clock_source),
    .internal_osc_run(internal_osc_run),
    .internal_osc_trim(internal_osc_trim),
    .internal_osc_ready(internal_osc_ready),
    .switch_pending(switch_pending)
);

// ==== bench/system_clock_source_select_bench.sv ====
/* Bench for the core clock selector: ticks every 4/8/10 clk.
   Assumes package, design and checker are compiled first. */
`timescale 1ns/100ps

module system_clock_source_select_bench;
    import scs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, internal_osc_control_enable = 1'b1;
    logic int_osc_tick = 1'b0, ext_osc_tick = 1'b0, rtc_osc_tick = 1'b0;
    logic core_clock, internal_osc_run, internal_osc_ready, switch_pending;
    logic [1:0] source_select = 2'h0, mult_base_select = 2'h0;
    logic [1:0] core_clock_source;
    logic [2:0] internal_osc_divide_select = 3'h7, mult_scale_select = 3'h0;
    logic [6:0] internal_osc_calibration = 7'h40, internal_osc_trim;
    logic [5:0] cnt = 6'h0;
    int errors = 0, samples_checked = 0;

    scs_core_clock_select #(.STALL_CYCLES(16'h0010))
        i_scs_core_clock_select (
        .clk(clk),
        .rst(rst),
        .source_select(source_select),
        .internal_osc_control_enable(internal_osc_control_enable),
        .internal_osc_calibration(internal_osc_calibration),
        .internal_osc_divide_select(internal_osc_divide_select),
        .mult_base_select(mult_base_select),
        .mult_scale_select(mult_scale_select),
        .int_osc_tick(int_osc_tick),
        .ext_osc_tick(ext_osc_tick),
        .rtc_osc_tick(rtc_osc_tick),
        .core_clock(core_clock),
        .core_clock_source(core_clock_source),
        .internal_osc_run(internal_osc_run),
        .internal_osc_trim(internal_osc_trim),
        .internal_osc_ready(internal_osc_ready),
        .switch_pending(switch_pending)
    );

    initial forever #12.5 clk = ~clk;

    // lcm of tick spacings is 40, so one counter serves all three
    always @(posedge clk) begin
        cnt <= (cnt == 6'h27) ? 6'h0 : cnt + 6'h1;
        int_osc_tick <= cnt[1:0] == 2'h0;
        ext_osc_tick <= cnt[2:0] == 3'h0;
        rtc_osc_tick <= cnt % 6'ha == 6'h0;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(inout int c);
        @(posedge clk);
        #1;
        c++;
        if (c > 3000) begin
            errors++;
            end_sim;
        end
    endtask

    // first rise may follow a partial phase, so keep the last count
    task automatic period(output int c);
        for (int i = 0; i < 3; i++) begin
            c = 0;
            while (core_clock === 1'b1) step(c);
            while (core_clock !== 1'b1) step(c);
        end
    endtask

    task automatic cfg(input logic [1:0] s, d, input logic [2:0] b, f);
        int c = 0;
        @(posedge clk);
        source_select <= s;
        internal_osc_divide_select <= b;
        mult_base_select <= d;
        mult_scale_select <= f;
        @(posedge clk);
        #1;
        chk(switch_pending, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        while (switch_pending === 1'b1) step(c);
        chk(core_clock_source, s);
    endtask

    task automatic t_reset;
        int c;
        chk({internal_osc_run, internal_osc_trim}, 8'hc0);
        chk(core_clock_source, SCS_SRC_INT);
        period(c);
        chk(c, 1024);
        $display("reset test done");
    endtask

    task automatic t_div;
        int c;
        for (int n = 0; n < 3; n++) begin
            cfg(2'h0, 2'h0, n[2:0], 3'h0);
            period(c);
            chk(c, 8 << n);
        end
        $display("divide test done");
    endtask

    task automatic t_src;
        int c;
        cfg(2'h1, 2'h0, 3'h0, 3'h0);
        period(c);
        chk(c, 16);
        cfg(2'h2, 2'h0, 3'h0, 3'h0);
        period(c);
        chk(c, 20);
        $display("source test done");
    endtask

    task automatic t_osc;
        @(posedge clk);
        internal_osc_calibration <= 7'h15;
        internal_osc_control_enable <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({internal_osc_run, internal_osc_ready, internal_osc_trim}, 9'h15);
        @(posedge clk);
        internal_osc_control_enable <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk({internal_osc_run, internal_osc_ready}, 2'h3);
        $display("oscillator test done");
    endtask

    task automatic t_mult;
        int c;
        for (int b = 0; b < 3; b++)
            for (int f = 0; f < 6; f++) begin
                cfg(2'h3, b[1:0], 3'h0, f[2:0]);
                period(c);
                chk(c, (b == 0 ? 4 : 8) * (f + 2) / (b == 2 ? 4 : 2));
            end
        $display("multiplier test done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_div;
        t_src;
        t_osc;
        t_mult;
        end_sim;
    end
endmodule
